// file: hsb_pkg.sv
// package of constants for the hot-swap sequencer and breaker
// Overview of operation
// - gate stays off until supply in window and card seated for qualification delay
// - switch counts as on only when drain comparator reports below threshold
// - filtered trip when sense stays above 50mV longer than filter time
// - fast trip at once above fast-trip level; disabled setting never trips
// - trip turns gate off and drives breaker fault low
// - manual mode: trip cleared only by restart input low then high
// - cycling mode: trip clears itself after retry interval, gate re-enabled
// - overcurrent still present after reset trips again by same criteria
// - restart input held low keeps gate off in both modes
// - gate off is a fast short to rail; turn-on is a slow ramp
// - power good only with supply in window, switch on, no sustained overcurrent
// - first, second after one sequence delay, third after a further delay
// - low gate inputs hold second and third power good inactive
// - power good outputs open-drain, active low
// - both seat detect inputs low before gate or power good enabled
// - mode select low gives manual reset, high gives self-restart cycling
// - cycling mode, restart high: gate re-enabled after retry interval
// - sequence delay selectable: 5ms, 20ms, 80ms or 160ms
package hsb_pkg;
    localparam int CLK_HZ = 100_000_000;
    localparam int QUAL_US = 100;
    localparam int RETRY_MS = 1000;
    localparam int PGD_MS_0 = 5;
    localparam int PGD_MS_1 = 20;
    localparam int PGD_MS_2 = 80;
    localparam int PGD_MS_3 = 160;
    localparam int CBD_US_0 = 5;
    localparam int CBD_US_1 = 50;
    localparam int CBD_US_2 = 150;
    localparam int CBD_US_3 = 400;
    localparam int QUAL_CYC = QUAL_US * (CLK_HZ / 1_000_000);
    localparam int RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);
    localparam int PGD_CYC_0 = PGD_MS_0 * (CLK_HZ / 1000);
    localparam int PGD_CYC_1 = PGD_MS_1 * (CLK_HZ / 1000);
    localparam int PGD_CYC_2 = PGD_MS_2 * (CLK_HZ / 1000);
    localparam int PGD_CYC_3 = PGD_MS_3 * (CLK_HZ / 1000);
    localparam int CBD_CYC_0 = CBD_US_0 * (CLK_HZ / 1_000_000);
    localparam int CBD_CYC_1 = CBD_US_1 * (CLK_HZ / 1_000_000);
    localparam int CBD_CYC_2 = CBD_US_2 * (CLK_HZ / 1_000_000);
    localparam int CBD_CYC_3 = CBD_US_3 * (CLK_HZ / 1_000_000);
    localparam logic [1:0] FAST_TRIP_OFF = 2'h0;
    typedef enum logic [2:0] {HSB_IDLE, HSB_QUAL, HSB_RAMP, HSB_ON, HSB_TRIP}
        hsb_state_t;
endpackage

// file: hsb_sync_if.sv
// interface carrying synchronised comparator levels
`timescale 1ns/1ps
interface hsb_sync_if;
    logic [8:0] raw;
    logic [8:0] lvl;
    modport src (input raw, output lvl);
    modport dst (output raw, input lvl);
endinterface

// file: hsb_sync.sv
// three-stage synchroniser for asynchronous comparator inputs
`timescale 1ns/1ps
module hsb_sync #(
    parameter int W = 9
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    hsb_sync_if.src port
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // a change counts only once the second and third stages agree
            always_ff @(posedge i_core_clk) begin
                if (!i_rst_n) begin
                    lvl[g] <= 1'b0;
                end else if (s2[g] == s3[g]) begin
                    lvl[g] <= s3[g];
                end
            end
        end
    endgenerate
    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= port.raw;
            s2 <= s1;
            s3 <= s2;
        end
    end
    assign port.lvl = lvl;
endmodule // hsb_sync

// file: hsb_top.sv
// hot-swap sequencer with circuit breaker
`timescale 1ns/1ps
module hsb_top
    import hsb_pkg::*;
#(
    parameter int QUAL_CYCLES = QUAL_CYC,
    parameter int RETRY_CYCLES = RETRY_CYC,
    parameter int PGD_C0 = PGD_CYC_0,
    parameter int PGD_C1 = PGD_CYC_1,
    parameter int PGD_C2 = PGD_CYC_2,
    parameter int PGD_C3 = PGD_CYC_3,
    parameter int CBD_C0 = CBD_CYC_0,
    parameter int CBD_C1 = CBD_CYC_1,
    parameter int CBD_C2 = CBD_CYC_2,
    parameter int CBD_C3 = CBD_CYC_3
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // comparator and pin inputs (asynchronous)
    input wire logic i_supply_low_compare,
    input wire logic i_supply_high_compare,
    input wire logic i_seat_detect_a_n,
    input wire logic i_seat_detect_b_n,
    input wire logic i_master_enable_temp,
    input wire logic i_drain_on_compare,
    input wire logic i_current_sense_in,
    input wire logic i_fast_trip_compare,
    input wire logic i_breaker_restart_n,
    // straps and gate inputs
    input wire logic i_breaker_mode_sel,
    input wire logic [1:0] i_sequence_delay,
    input wire logic [1:0] i_breaker_filter_sel,
    input wire logic [1:0] i_fast_trip_level,
    input wire logic i_second_output_gate,
    input wire logic i_third_output_gate,
    // gate drive
    output logic o_gate_ramp_on,
    output logic o_gate_short_off,
    // open-drain outputs: enable high pulls the pin low
    output logic o_breaker_fault_n,
    output logic o_breaker_fault_oe,
    output logic o_power_good_first_n,
    output logic o_power_good_first_oe,
    output logic o_power_good_second_n,
    output logic o_power_good_second_oe,
    output logic o_power_good_third_n,
    output logic o_power_good_third_oe
);
    hsb_sync_if sif ();
    // second and third gate inputs also come from pins and are synchronised
    assign sif.raw = {i_third_output_gate, i_second_output_gate, i_breaker_restart_n,
        i_fast_trip_compare, i_current_sense_in, i_drain_on_compare,
        i_master_enable_temp, ~(i_seat_detect_a_n | i_seat_detect_b_n),
        ~i_supply_low_compare & ~i_supply_high_compare};
    hsb_sync #(.W(9)) u_sync (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .port(sif.src)
    );

    wire in_window = sif.lvl[0];
    wire seated = sif.lvl[1];
    wire master_en = sif.lvl[2];
    wire drain_on = sif.lvl[3];
    wire over_50mv = sif.lvl[4];
    wire fast_cmp = sif.lvl[5];
    wire restart_n = sif.lvl[6];
    wire gate2 = sif.lvl[7];
    wire gate3 = sif.lvl[8];

    hsb_state_t state;
    hsb_state_t next_state;
    logic [31:0] cnt;
    logic [31:0] cbd_cnt;
    logic [31:0] pg_cnt;
    logic [1:0] pg_stage;
    logic restart_seen_low;
    logic restart_prev;

    wire ready = in_window & seated & master_en & restart_n;
    wire [31:0] cbd_lim = (i_breaker_filter_sel == 2'h0) ? 32'(CBD_C0) :
        (i_breaker_filter_sel == 2'h1) ? 32'(CBD_C1) :
        (i_breaker_filter_sel == 2'h2) ? 32'(CBD_C2) : 32'(CBD_C3);
    wire [31:0] pgd_lim = (i_sequence_delay == 2'h0) ? 32'(PGD_C0) :
        (i_sequence_delay == 2'h1) ? 32'(PGD_C1) :
        (i_sequence_delay == 2'h2) ? 32'(PGD_C2) : 32'(PGD_C3);
    wire gate_active = (state == HSB_RAMP) | (state == HSB_ON);
    wire filt_trip = over_50mv & (cbd_cnt >= cbd_lim);
    wire fast_trip = fast_cmp & (i_fast_trip_level != FAST_TRIP_OFF);
    wire trip = gate_active & (filt_trip | fast_trip);
    wire restart_rise = restart_n & ~restart_prev;
    // manual mode: leave only on low-then-high; cycling: timer after restart high
    wire clear_manual = ~i_breaker_mode_sel & restart_seen_low & restart_rise;
    wire clear_cycle = i_breaker_mode_sel & restart_n &
        (cnt >= 32'(RETRY_CYCLES));
    wire pg_ok = (state == HSB_ON) & in_window & drain_on;
    // power good falls on the same edge as the gate, never one cycle behind it
    wire pg_keep = pg_ok & (next_state == HSB_ON);

    always_comb begin
        next_state = state;
        case (state)
            HSB_IDLE: begin
                if (ready) begin
                    next_state = HSB_QUAL;
                end
            end
            HSB_QUAL: begin
                if (!ready) begin
                    next_state = HSB_IDLE;
                end else if (cnt >= 32'(QUAL_CYCLES)) begin
                    next_state = HSB_RAMP;
                end
            end
            HSB_RAMP, HSB_ON: begin
                if (trip) begin
                    next_state = HSB_TRIP;
                end else if (!ready) begin
                    next_state = HSB_IDLE;
                end else if (drain_on) begin
                    next_state = HSB_ON;
                end
            end
            HSB_TRIP: begin
                if (clear_manual || clear_cycle) begin
                    next_state = HSB_IDLE;
                end
            end
            default: next_state = HSB_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state <= HSB_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            // cycling retry counts only while restart is high, so a held-low
            // restart delays the retry interval until after its release
            if (next_state != state || (state == HSB_TRIP && !restart_n)) begin
                cnt <= '0;
            end else if (cnt != '1) begin
                cnt <= cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            cbd_cnt <= '0;
        end else if (over_50mv && gate_active) begin
            cbd_cnt <= (cbd_cnt != '1) ? cbd_cnt + 32'h0000_0001 : cbd_cnt;
        end else begin
            cbd_cnt <= '0;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            restart_prev <= 1'b1;
            restart_seen_low <= 1'b0;
        end else begin
            restart_prev <= restart_n;
            if (state != HSB_TRIP) begin
                restart_seen_low <= 1'b0;
            end else if (!restart_n) begin
                restart_seen_low <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            pg_stage <= 2'h0;
            pg_cnt <= '0;
        end else if (!pg_ok) begin
            pg_stage <= 2'h0;
            pg_cnt <= '0;
        end else if (pg_stage == 2'h0) begin
            pg_stage <= 2'h1;
            pg_cnt <= '0;
        end else if (pg_stage != 2'h3 && pg_cnt + 32'h0000_0001 >= pgd_lim) begin
            pg_stage <= pg_stage + 2'h1;
            pg_cnt <= '0;
        end else if (pg_stage != 2'h3) begin
            pg_cnt <= pg_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_gate_ramp_on <= 1'b0;
            o_gate_short_off <= 1'b1;
            // open-drain data sits low from reset on; only the enables ever move
            o_breaker_fault_n <= 1'b0;
            o_breaker_fault_oe <= 1'b0;
            o_power_good_first_n <= 1'b0;
            o_power_good_first_oe <= 1'b0;
            o_power_good_second_n <= 1'b0;
            o_power_good_second_oe <= 1'b0;
            o_power_good_third_n <= 1'b0;
            o_power_good_third_oe <= 1'b0;
        end else begin
            // ramp is current-limited externally; off is a hard short
            o_gate_ramp_on <= (next_state == HSB_RAMP) | (next_state == HSB_ON);
            o_gate_short_off <= ~((next_state == HSB_RAMP) | (next_state == HSB_ON));
            o_breaker_fault_n <= 1'b0;
            o_breaker_fault_oe <= (next_state == HSB_TRIP);
            o_power_good_first_n <= 1'b0;
            o_power_good_first_oe <= pg_keep & (pg_stage >= 2'h1);
            o_power_good_second_n <= 1'b0;
            o_power_good_second_oe <= pg_keep & (pg_stage >= 2'h2) & gate2;
            o_power_good_third_n <= 1'b0;
            o_power_good_third_oe <= pg_keep & (pg_stage >= 2'h3) & gate3;
        end
    end
endmodule // hsb_top

// file: hsb_switch_model.sv
// behavioural model of the external switch and its drain comparator
`timescale 1ns/1ps
module hsb_switch_model #(
    parameter int RAMP_CYCLES = 10
) (
    // gate drive from the controller
    input wire logic i_core_clk,
    input wire logic i_gate_ramp_on,
    input wire logic i_gate_short_off,
    // comparator back to the controller
    output logic o_drain_on_compare
);
    int ramp_count;
    // slow charge while ramping, instant discharge on short
    always_ff @(posedge i_core_clk) begin
        if (i_gate_short_off) begin
            ramp_count <= 0;
        end else if (i_gate_ramp_on && ramp_count < RAMP_CYCLES) begin
            ramp_count <= ramp_count + 1;
        end
    end
    // drain reads on only once the gate has charged, never straight away
    assign o_drain_on_compare = (ramp_count >= RAMP_CYCLES);
endmodule // hsb_switch_model

// file: hsb_top_props.sv
// concurrent checks on the ports of the hot-swap top
`timescale 1ns/1ps
module hsb_props (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // inputs watched
    input wire logic i_seat_detect_a_n,
    input wire logic i_seat_detect_b_n,
    input wire logic i_breaker_restart_n,
    input wire logic i_fast_trip_compare,
    input wire logic [1:0] i_fast_trip_level,
    input wire logic i_second_output_gate,
    input wire logic i_third_output_gate,
    // outputs watched
    input wire logic o_gate_ramp_on,
    input wire logic o_gate_short_off,
    input wire logic o_breaker_fault_n,
    input wire logic o_breaker_fault_oe,
    input wire logic o_power_good_first_n,
    input wire logic o_power_good_first_oe,
    input wire logic o_power_good_second_oe,
    input wire logic o_power_good_third_oe
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    seat_hold_a: assert property ((i_seat_detect_a_n || i_seat_detect_b_n) [*8]
        |-> !o_gate_ramp_on)
        else $error("gate on without card seated");
    restart_hold_a: assert property (!i_breaker_restart_n [*8] |-> !o_gate_ramp_on)
        else $error("gate on while restart held low");
    drive_pair_a: assert property (o_gate_short_off == !o_gate_ramp_on)
        else $error("gate short and ramp not exclusive");
    trip_off_a: assert property (o_breaker_fault_oe |->
        !o_gate_ramp_on && !o_power_good_first_oe)
        else $error("gate or power good on while tripped");
    fast_trip_a: assert property ($rose(i_fast_trip_compare)
        && i_fast_trip_level != 2'h0 && o_gate_ramp_on && i_breaker_restart_n
        |-> ##[1:8] o_breaker_fault_oe)
        else $error("fast trip not taken");
    good_order_a: assert property (o_power_good_second_oe || o_power_good_third_oe
        |-> o_power_good_first_oe)
        else $error("later power good before first");
    good_needs_gate_a: assert property (o_power_good_first_oe |-> o_gate_ramp_on)
        else $error("power good without gate on");
    second_gate_a: assert property (!i_second_output_gate [*6]
        |-> !o_power_good_second_oe)
        else $error("second power good not held off");
    third_gate_a: assert property (!i_third_output_gate [*6]
        |-> !o_power_good_third_oe)
        else $error("third power good not held off");
    drain_low_a: assert property (o_power_good_first_n == 1'b0
        && o_breaker_fault_n == 1'b0)
        else $error("open-drain data not low");
endmodule // hsb_props
bind hsb_top hsb_props i_props (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_seat_detect_a_n(i_seat_detect_a_n),
    .i_seat_detect_b_n(i_seat_detect_b_n),
    .i_breaker_restart_n(i_breaker_restart_n),
    .i_fast_trip_compare(i_fast_trip_compare),
    .i_fast_trip_level(i_fast_trip_level),
    .i_second_output_gate(i_second_output_gate),
    .i_third_output_gate(i_third_output_gate),
    .o_gate_ramp_on(o_gate_ramp_on),
    .o_gate_short_off(o_gate_short_off),
    .o_breaker_fault_n(o_breaker_fault_n),
    .o_breaker_fault_oe(o_breaker_fault_oe),
    .o_power_good_first_n(o_power_good_first_n),
    .o_power_good_first_oe(o_power_good_first_oe),
    .o_power_good_second_oe(o_power_good_second_oe),
    .o_power_good_third_oe(o_power_good_third_oe)
);

// file: test_hot_swap_sequencer_breaker.sv
// self-checking bench for the hot-swap sequencer and breaker
`timescale 1ns/1ps
module test_hot_swap_sequencer_breaker;
    import hsb_pkg::*;
    localparam int QC = 20;
    localparam int RC = 50;
    localparam int CB = 20;
    localparam int PG [4] = '{20, 40, 60, 80};
    logic clk = 0, rst_n = 0, uv = 0, ov = 0, sa = 1, sb = 1, en = 1, cs = 0, ft = 0, rs = 1;
    logic mode = 0, g2 = 1, g3 = 1, drain, ramp, short, fn, foe, p1n, p1oe, p2n, p2oe, p3n, p3oe;
    logic [1:0] sequence_delay = 2'h0, fsel = 2'h2, flev = 2'h0;
    int fail_count = 0, tests_run = 0, c, d;
    // the shortest filter keeps its real length, so it is checked against the package
    hsb_top #(.QUAL_CYCLES(QC), .RETRY_CYCLES(RC), .PGD_C0(PG[0]), .PGD_C1(PG[1]),
        .PGD_C2(PG[2]), .PGD_C3(PG[3]), .CBD_C2(CB)) i_dut (
        .i_core_clk(clk), .i_rst_n(rst_n), .i_supply_low_compare(uv), .i_supply_high_compare(ov),
        .i_seat_detect_a_n(sa), .i_seat_detect_b_n(sb), .i_master_enable_temp(en),
        .i_drain_on_compare(drain), .i_current_sense_in(cs), .i_fast_trip_compare(ft),
        .i_breaker_restart_n(rs), .i_breaker_mode_sel(mode), .i_sequence_delay(sequence_delay),
        .i_breaker_filter_sel(fsel), .i_fast_trip_level(flev), .i_second_output_gate(g2),
        .i_third_output_gate(g3), .o_gate_ramp_on(ramp), .o_gate_short_off(short),
        .o_breaker_fault_n(fn), .o_breaker_fault_oe(foe), .o_power_good_first_n(p1n),
        .o_power_good_first_oe(p1oe), .o_power_good_second_n(p2n), .o_power_good_second_oe(p2oe),
        .o_power_good_third_n(p3n), .o_power_good_third_oe(p3oe));
    hsb_switch_model i_switch (.i_core_clk(clk), .i_gate_ramp_on(ramp), .i_gate_short_off(short),
        .o_drain_on_compare(drain));
    initial begin
        forever #5 clk = ~clk;
    end
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // counts cycles until the chosen output is high; a hang ends the run
    task wait_on(input int which, output int cyc);
        logic s;
        cyc = 0;
        s = 0;
        while (s !== 1'b1) begin
            @(negedge clk);
            cyc++;
            case (which)
                0: s = ramp;
                1: s = p1oe;
                2: s = p2oe;
                3: s = p3oe;
                default: s = foe;
            endcase
            if (cyc > 3000) begin
                fail_count++;
                conclude();
            end
        end
    endtask
    // restart pulse: drops to idle, clears a manual trip
    task pulse_restart;
        @(posedge clk) rs <= 0;
        repeat (10) @(posedge clk);
        rs <= 1;
    endtask
    task t_sequence;
        @(posedge clk) sa <= 0;
        repeat (40) @(negedge clk);
        chk("gate one seat", 0, ramp);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk) sequence_delay <= k[1:0];
            sb <= 0;
            wait_on(0, c);
            chk("qualify", 1, c >= QC && c <= QC + 10);
            wait_on(1, c);
            chk("drain on", 1, drain);
            wait_on(2, d);
            chk("second delay", 1, d >= PG[k] && d <= PG[k] + 2);
            wait_on(3, d);
            chk("third delay", 1, d >= PG[k] && d <= PG[k] + 2);
            if (k < 3) pulse_restart();
        end
    endtask
    task t_gates;
        @(posedge clk) g2 <= 0;
        repeat (8) @(negedge clk);
        chk("second gated", 2'b01, {p2oe, p1oe});
        @(posedge clk) g2 <= 1;
        g3 <= 0;
        repeat (8) @(negedge clk);
        chk("third gated", 3'b011, {p3oe, p2oe, p1oe});
        @(posedge clk) g3 <= 1;
    endtask
    task t_manual;
        @(posedge clk) cs <= 1;
        wait_on(4, c);
        chk("filter time", 1, c >= CB && c <= CB + 10);
        chk("trip outputs", 3'b100, {short, ramp, p1oe});
        @(posedge clk) cs <= 0;
        repeat (RC + QC + 20) @(negedge clk);
        chk("manual latch", 2'b10, {foe, ramp});
        pulse_restart();
        wait_on(0, c);
        chk("manual clear", 0, foe);
        @(posedge clk) cs <= 1;
        fsel <= 2'h0;
        wait_on(4, c);
        chk("retrip", 1, c >= CBD_CYC_0 && c <= CBD_CYC_0 + 10);
        @(posedge clk) cs <= 0;
    endtask
    task t_cycling;
        @(posedge clk) mode <= 1;
        pulse_restart();
        wait_on(1, c);
        @(posedge clk) ft <= 1;
        repeat (30) @(negedge clk);
        chk("fast off", 0, foe);
        // let the low level pass the synchroniser before arming, or arming trips at once
        @(posedge clk) ft <= 0;
        repeat (6) @(posedge clk);
        flev <= 2'h1;
        repeat (2) @(posedge clk);
        ft <= 1;
        wait_on(4, c);
        chk("fast time", 1, c >= 3 && c <= 8);
        @(posedge clk) ft <= 0;
        wait_on(0, c);
        chk("retry time", 1, c >= RC + QC - 2 && c <= RC + QC + 12);
    endtask
    task t_window;
        wait_on(1, c);
        @(posedge clk) ov <= 1;
        repeat (8) @(negedge clk);
        chk("window high", 3'b000, {ramp, p1oe, foe});
        @(posedge clk) ov <= 0;
        wait_on(1, c);
        @(posedge clk) uv <= 1;
        repeat (8) @(negedge clk);
        chk("window low", 3'b000, {ramp, p1oe, foe});
        @(posedge clk) uv <= 0;
        en <= 0;
        repeat (40) @(negedge clk);
        chk("master off", 0, ramp);
        @(posedge clk) en <= 1;
        wait_on(0, c);
        chk("master on", 1, c >= QC && c <= QC + 10);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1;
        @(negedge clk);
        chk("reset state", 4'b1000, {short, ramp, foe, p1oe});
        chk("drain data", 4'b0000, {fn, p1n, p2n, p3n});
        t_sequence();
        t_gates();
        t_manual();
        t_cycling();
        t_window();
        conclude();
    end
endmodule // test_hot_swap_sequencer_breaker
